// ---- cpg_top.sv ----
// complementary pwm group with axi4-lite register access
`timescale 1ns/100ps
module cpg_top
  import cpg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        fault_input_pin,
  output logic             primary_output,
  output logic             secondary_output,
  output logic             primary_drive,
  output logic             secondary_drive,
  output logic             overflow_irq_request
);

  // ==================================================
  // bus handshake state
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic        aw_high_zero;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        aw_take;
  logic        w_take;
  logic        b_done;
  logic        wr_fire;
  logic        ar_take;
  logic        next_aw_full;
  logic        next_w_full;
  logic        next_rvalid;

  assign aw_take      = s_axi_awvalid & s_axi_awready;
  assign w_take       = s_axi_wvalid & s_axi_wready;
  assign b_done       = s_axi_bvalid & s_axi_bready;
  assign wr_fire      = aw_full & w_full & ~s_axi_bvalid;
  assign ar_take      = s_axi_arvalid & s_axi_arready;
  assign next_aw_full = ~b_done & (aw_full | aw_take);
  assign next_w_full  = ~b_done & (w_full | w_take);
  assign next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_addr      <= RESET_BYTE;
      aw_high_zero <= 1'b0;
      w_byte       <= RESET_BYTE;
      w_lane0      <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr      <= s_axi_awaddr[7:0];
        aw_high_zero <= (s_axi_awaddr[31:8] == 24'h000000);
      end
      if (w_take) begin
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // ==================================================
  // write decode: only byte lane 0 carries register data
  logic wr_ok;
  logic wr_hit;
  logic wr_enable;
  logic wr_control;
  logic wr_per_lo;
  logic wr_per_hi;
  logic wr_duty_lo;
  logic wr_duty_hi;
  logic wr_dt_lo;
  logic wr_dt_hi;

  assign wr_ok      = wr_fire & aw_high_zero & w_lane0;
  assign wr_enable  = wr_ok & (aw_addr == ADDR_ENABLE);
  assign wr_control = wr_ok & (aw_addr == ADDR_CONTROL);
  assign wr_per_lo  = wr_ok & (aw_addr == ADDR_PERIOD_LO);
  assign wr_per_hi  = wr_ok & (aw_addr == ADDR_PERIOD_HI);
  assign wr_duty_lo = wr_ok & (aw_addr == ADDR_DUTY_LO);
  assign wr_duty_hi = wr_ok & (aw_addr == ADDR_DUTY_HI);
  assign wr_dt_lo   = wr_ok & (aw_addr == ADDR_DT_LO);
  assign wr_dt_hi   = wr_ok & (aw_addr == ADDR_DT_HI);
  assign wr_hit     = aw_high_zero & (aw_addr[1:0] == 2'h0) & (aw_addr <= ADDR_DT_HI);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      s_axi_bvalid <= wr_fire | (s_axi_bvalid & ~s_axi_bready);
      if (wr_fire) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==================================================
  // configuration registers
  logic       group_enable_bit;
  logic       primary_output_enable;
  logic       secondary_output_enable;
  logic       pairing_mode_select;
  logic       fault_detect_enable;
  logic [1:0] fault_level_select;
  logic       overflow_irq_enable;
  logic       overflow_irq_flag;
  logic       fault_status;
  logic       fault_pin_polarity;
  logic [1:0] output_polarity_select;
  logic [1:0] clock_divider_select;
  logic [7:0] period_low_byte;
  logic [3:0] period_high_nibble;
  logic [7:0] duty_low_byte;
  logic [3:0] duty_high_nibble;
  logic [7:0] deadtime_low_byte;
  logic [3:0] deadtime_high_nibble;
  logic       group_start;
  logic       overflow;
  logic       fault_hit;

  // a start only counts when the group was off; rewriting 1 does not recount
  assign group_start = wr_enable & w_byte[EN_GROUP_BIT] & ~group_enable_bit;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      group_enable_bit        <= 1'b0;
      primary_output_enable   <= 1'b0;
      secondary_output_enable <= 1'b0;
      pairing_mode_select     <= 1'b0;
      fault_detect_enable     <= 1'b0;
      fault_level_select      <= 2'h0;
    end else if (wr_enable) begin
      group_enable_bit        <= w_byte[EN_GROUP_BIT];
      primary_output_enable   <= w_byte[EN_PRIMARY_BIT];
      secondary_output_enable <= w_byte[EN_SECOND_BIT];
      pairing_mode_select     <= w_byte[EN_MODE_BIT];
      fault_detect_enable     <= w_byte[EN_FAULT_EN_BIT];
      fault_level_select      <= w_byte[EN_FLT_PRI_BIT:EN_FLT_SEC_BIT];
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overflow_irq_enable    <= 1'b0;
      overflow_irq_flag      <= 1'b0;
      fault_status           <= 1'b0;
      fault_pin_polarity     <= 1'b0;
      output_polarity_select <= 2'h0;
      clock_divider_select   <= 2'h0;
    end else begin
      if (wr_control) begin
        overflow_irq_enable    <= w_byte[CT_IRQ_EN_BIT];
        fault_pin_polarity     <= w_byte[CT_FLT_POL_BIT];
        output_polarity_select <= w_byte[CT_POL_PRI_BIT:CT_POL_SEC_BIT];
        clock_divider_select   <= w_byte[CT_CLK_LSB+1:CT_CLK_LSB];
      end
      overflow_irq_flag <= overflow | (overflow_irq_flag &
                           ~(wr_control & ~w_byte[CT_IRQ_FLAG_BIT]));
      fault_status      <= fault_hit | (fault_status &
                           ~(wr_control & ~w_byte[CT_FLT_STAT_BIT]));
    end
  end

  // ==================================================
  // value registers, shadows and active copies
  logic [11:0] period_shadow;
  logic [11:0] duty_shadow;
  logic [11:0] deadtime_shadow;
  logic [11:0] period_active;
  logic [11:0] duty_active;
  logic [11:0] deadtime_active;
  logic        load_active;

  assign load_active = overflow | group_start;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      period_low_byte      <= RESET_BYTE;
      period_high_nibble   <= 4'h0;
      duty_low_byte        <= RESET_BYTE;
      duty_high_nibble     <= 4'h0;
      deadtime_low_byte    <= RESET_BYTE;
      deadtime_high_nibble <= 4'h0;
      period_shadow        <= RESET_VALUE;
      duty_shadow          <= RESET_VALUE;
      deadtime_shadow      <= RESET_VALUE;
    end else begin
      if (wr_per_hi) period_high_nibble <= w_byte[3:0];
      if (wr_duty_hi) duty_high_nibble <= w_byte[3:0];
      if (wr_dt_hi) deadtime_high_nibble <= w_byte[3:0];
      if (wr_per_lo) begin
        period_low_byte <= w_byte;
        period_shadow   <= {period_high_nibble, w_byte};
      end
      if (wr_duty_lo) begin
        duty_low_byte <= w_byte;
        duty_shadow   <= {duty_high_nibble, w_byte};
      end
      if (wr_dt_lo) begin
        deadtime_low_byte <= w_byte;
        deadtime_shadow   <= {deadtime_high_nibble, w_byte};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      period_active   <= RESET_VALUE;
      duty_active     <= RESET_VALUE;
      deadtime_active <= RESET_VALUE;
    end else if (load_active) begin
      period_active   <= period_shadow;
      duty_active     <= duty_shadow;
      deadtime_active <= deadtime_shadow;
    end
  end

  // ==================================================
  // period counter
  logic        tick;
  logic [11:0] count;
  logic [11:0] next_count;

  cpg_prescaler cpg_prescaler_inst (
    .clk_sys              (clk_sys),
    .reset_n              (reset_n),
    .restart              (group_start),
    .clock_divider_select (clock_divider_select),
    .tick                 (tick)
  );

  // counts regardless of output enables, so the group doubles as a timer
  assign overflow   = group_enable_bit & tick & (count >= period_active);
  assign next_count = (group_start | overflow) ? COUNT_START :
                      (group_enable_bit & tick) ? count + 12'h001 : count;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= RESET_VALUE;
    end else begin
      count <= next_count;
    end
  end

  // ==================================================
  // fault pin: three stages, a change counts when stages two and three agree
  logic [2:0] fault_sync;
  logic       fault_level;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_sync  <= 3'h0;
      fault_level <= 1'b0;
    end else begin
      fault_sync <= {fault_sync[1:0], fault_input_pin};
      if (fault_sync[1] == fault_sync[2]) fault_level <= fault_sync[2];
    end
  end

  assign fault_hit = fault_detect_enable & (fault_level == fault_pin_polarity);

  // ==================================================
  // waveform
  logic [12:0] duty_plus_dead;
  logic        comp_primary;
  logic        comp_secondary;
  logic        primary_active;
  logic        secondary_active;
  logic        next_primary_drive;
  logic        next_secondary_drive;
  logic        next_primary_output;
  logic        next_secondary_output;

  assign duty_plus_dead   = {1'b0, duty_active} + {1'b0, deadtime_active};
  // dead time is cut from the start of each active portion, so both edges see it
  assign comp_primary     = (count > deadtime_active) & (count <= duty_active);
  assign comp_secondary   = ({1'b0, count} > duty_plus_dead);
  assign primary_active   = pairing_mode_select ? (count <= duty_active) : comp_primary;
  assign secondary_active = pairing_mode_select ? (count <= deadtime_active) :
                            comp_secondary;
  assign next_primary_drive   = group_enable_bit & primary_output_enable;
  assign next_secondary_drive = group_enable_bit & secondary_output_enable;
  // an undriven pin rests at its inactive level
  assign next_primary_output   = ~next_primary_drive ? output_polarity_select[1] :
                                 fault_status ? fault_level_select[1] :
                                 (primary_active ^ output_polarity_select[1]);
  assign next_secondary_output = ~next_secondary_drive ? output_polarity_select[0] :
                                 fault_status ? fault_level_select[0] :
                                 (secondary_active ^ output_polarity_select[0]);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      primary_drive        <= 1'b0;
      secondary_drive      <= 1'b0;
      primary_output       <= 1'b0;
      secondary_output     <= 1'b0;
      overflow_irq_request <= 1'b0;
    end else begin
      primary_drive        <= next_primary_drive;
      secondary_drive      <= next_secondary_drive;
      primary_output       <= next_primary_output;
      secondary_output     <= next_secondary_output;
      overflow_irq_request <= overflow_irq_flag & overflow_irq_enable;
    end
  end

  // ==================================================
  // read path
  logic [7:0] enable_view;
  logic [7:0] control_view;
  logic [7:0] read_byte;
  logic       rd_hit;

  assign enable_view  = {1'b0, fault_level_select, fault_detect_enable, pairing_mode_select,
                         secondary_output_enable, primary_output_enable, group_enable_bit};
  assign control_view = {overflow_irq_enable, overflow_irq_flag, fault_status,
                         fault_pin_polarity, output_polarity_select, clock_divider_select};
  assign rd_hit    = (s_axi_araddr[31:8] == 24'h000000) & (s_axi_araddr[1:0] == 2'h0) &
                     (s_axi_araddr[7:0] <= ADDR_DT_HI);
  assign read_byte = (s_axi_araddr[7:0] == ADDR_ENABLE)    ? enable_view :
                     (s_axi_araddr[7:0] == ADDR_CONTROL)   ? control_view :
                     (s_axi_araddr[7:0] == ADDR_PERIOD_LO) ? period_low_byte :
                     (s_axi_araddr[7:0] == ADDR_PERIOD_HI) ? {4'h0, period_high_nibble} :
                     (s_axi_araddr[7:0] == ADDR_DUTY_LO)   ? duty_low_byte :
                     (s_axi_araddr[7:0] == ADDR_DUTY_HI)   ? {4'h0, duty_high_nibble} :
                     (s_axi_araddr[7:0] == ADDR_DT_LO)     ? deadtime_low_byte :
                     (s_axi_araddr[7:0] == ADDR_DT_HI)     ? {4'h0, deadtime_high_nibble} :
                     8'h00;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= {24'h000000, rd_hit ? read_byte : 8'h00};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  restart_count_a: assert property (group_start |=> count == COUNT_START)
    else $error("group start did not reload the counter with one");
  stop_outputs_a: assert property ($fell(group_enable_bit) |=>
                                  !primary_drive && !secondary_drive)
    else $error("outputs still driven after group disable");
  counter_hold_a: assert property (!group_enable_bit && !group_start |=> $stable(count))
    else $error("counter moved while group disabled");
  primary_gate_a: assert property (!primary_output_enable |=> !primary_drive)
    else $error("primary driven while its enable is low");
  secondary_gate_a: assert property (!secondary_output_enable |=> !secondary_drive)
    else $error("secondary driven while its enable is low");
  timer_count_a: assert property (group_enable_bit && tick && !overflow && !group_start
                                  |=> count == $past(count) + 12'h001)
    else $error("counter did not advance on a tick");
  overflow_flag_a: assert property (overflow |=> overflow_irq_flag ##1
                                    (overflow_irq_request == $past(overflow_irq_enable)))
    else $error("overflow flag or interrupt request wrong");
  fault_set_a: assert property (fault_hit |=> fault_status)
    else $error("fault did not set the fault status");
  fault_level_a: assert property (fault_status && next_primary_drive |=>
                                  primary_output == $past(fault_level_select[1]))
    else $error("primary output not at fault level");
  shadow_load_a: assert property (overflow |=> period_active == $past(period_shadow)
                                  && duty_active == $past(duty_shadow))
    else $error("active values not taken from shadows on overflow");
  dead_gap_a: assert property (!pairing_mode_select |-> !(primary_active && secondary_active))
    else $error("both outputs active in complementary mode");
  write_answer_a: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  overflow_seen_c: cover property (overflow && primary_drive);
  fault_seen_c: cover property (fault_hit ##1 fault_status ##[1:50] !fault_status);
  indep_both_c: cover property (pairing_mode_select && primary_active && secondary_active);

endmodule : cpg_top

// ---- cpg_pkg.sv ----
// constants, register map and field layout of the complementary pwm group
package cpg_pkg;

  // ==================================================
  // register byte addresses
  localparam logic [7:0] ADDR_ENABLE    = 8'h00;
  localparam logic [7:0] ADDR_CONTROL   = 8'h04;
  localparam logic [7:0] ADDR_PERIOD_LO = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_HI = 8'h0c;
  localparam logic [7:0] ADDR_DUTY_LO   = 8'h10;
  localparam logic [7:0] ADDR_DUTY_HI   = 8'h14;
  localparam logic [7:0] ADDR_DT_LO     = 8'h18;
  localparam logic [7:0] ADDR_DT_HI     = 8'h1c;

  // ==================================================
  // enable register fields
  localparam int EN_GROUP_BIT    = 0;
  localparam int EN_PRIMARY_BIT  = 1;
  localparam int EN_SECOND_BIT   = 2;
  localparam int EN_MODE_BIT     = 3;
  localparam int EN_FAULT_EN_BIT = 4;
  localparam int EN_FLT_SEC_BIT  = 5;
  localparam int EN_FLT_PRI_BIT  = 6;

  // ==================================================
  // control register fields
  localparam int CT_CLK_LSB      = 0;
  localparam int CT_POL_SEC_BIT  = 2;
  localparam int CT_POL_PRI_BIT  = 3;
  localparam int CT_FLT_POL_BIT  = 4;
  localparam int CT_FLT_STAT_BIT = 5;
  localparam int CT_IRQ_FLAG_BIT = 6;
  localparam int CT_IRQ_EN_BIT   = 7;

  // ==================================================
  // reset values and counts
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [11:0] RESET_VALUE  = 12'h000;
  localparam logic [11:0] COUNT_START  = 12'h001;
  localparam logic [6:0]  DIV1_LAST    = 7'h00;
  localparam logic [6:0]  DIV8_LAST    = 7'h07;
  localparam logic [6:0]  DIV32_LAST   = 7'h1f;
  localparam logic [6:0]  DIV128_LAST  = 7'h7f;

  // ==================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cpg_pkg

// ---- cpg_prescaler.sv ----
// counting-clock tick generator for the pwm group
`timescale 1ns/100ps
module cpg_prescaler
  import cpg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       restart,
  input  wire logic [1:0] clock_divider_select,
  output logic            tick
);

  logic [6:0] div_count;
  logic [6:0] next_div_count;
  logic [6:0] div_last;

  // ==================================================
  // divider selection
  assign div_last = (clock_divider_select == 2'h0) ? DIV1_LAST :
                    (clock_divider_select == 2'h1) ? DIV8_LAST :
                    (clock_divider_select == 2'h2) ? DIV32_LAST : DIV128_LAST;
  // >= so a smaller divider picked mid-count still ticks at once
  assign tick = (div_count >= div_last);
  assign next_div_count = (restart | tick) ? 7'h00 : div_count + 7'h01;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= 7'h00;
    end else begin
      div_count <= next_div_count;
    end
  end

endmodule : cpg_prescaler

// ---- cpg_fault_source.sv ----
// stand-in for the external fault detector that feeds the fault pin
`timescale 1ns/100ps
module cpg_fault_source (
  input  wire logic trip,
  input  wire logic trip_high,
  output logic      fault_input_pin
);
  // idle level is the non-tripping one, so a stale pin never reads as a fault
  assign fault_input_pin = trip_high ? trip : ~trip;
endmodule : cpg_fault_source

// ---- complementary_pwm_group_12bit_tb_top.sv ----
// self-checking bench for the complementary pwm group
`timescale 1ns/100ps
module complementary_pwm_group_12bit_tb_top
  import cpg_pkg::*;
;
  logic        clk_sys, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, fault_input_pin, primary_output;
  logic        secondary_output, primary_drive, secondary_drive, overflow_irq_request;
  logic        trip, trip_high;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count, n_checks, pc, sc, dv;
  cpg_top cpg_top_inst (.*);
  cpg_fault_source cpg_fault_source_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========
  // bus and compare tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs = RESP_OKAY);
    @(posedge clk_sys);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(rs));
  endtask : wr
  task automatic rd(input logic [7:0] a, m, e, input logic [1:0] rs, input string what);
    @(posedge clk_sys);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(what, {s_axi_rresp, s_axi_rdata[29:0] & 30'(m)}, {rs, 30'(e)});
  endtask : rd
  // counting whole periods makes the figures independent of phase
  task automatic meas(input int n);
    pc = 0;
    sc = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (primary_output === 1'b1) pc++;
      if (secondary_output === 1'b1) sc++;
    end
  endtask : meas
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // ==========
  // tests
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, trip, trip_high} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int a = 0; a < 32; a += 4) rd(8'(a), 8'hff, 8'h00, RESP_OKAY, "reset");
    for (int a = 12; a < 32; a += 8) begin
      wr(8'(a), 8'hff);
      rd(8'(a), 8'hff, 8'h0f, RESP_OKAY, "high nibble");
      wr(8'(a), 8'h00);
    end
    wr(8'h20, 8'h5a, RESP_SLVERR);
    rd(8'h20, 8'hff, 8'h00, RESP_SLVERR, "unmapped");
    wr(ADDR_PERIOD_LO, 8'h08);
    wr(ADDR_DUTY_LO, 8'h04);
    wr(ADDR_DT_LO, 8'h01);
    for (int i = 0; i < 4; i++) begin
      dv = (i == 0) ? 1 : (1 << (2 * i + 1));
      wr(ADDR_ENABLE, 8'h00);
      wr(ADDR_CONTROL, 8'(i * 5));
      wr(ADDR_ENABLE, 8'h07);
      repeat (16 * dv) @(posedge clk_sys);
      meas(80 * dv);
      chk("primary active", 32'(pc), 32'(i[1] ? 50 * dv : 30 * dv));
      chk("secondary active", 32'(sc), 32'(i[0] ? 50 * dv : 30 * dv));
    end
    wr(ADDR_ENABLE, 8'h00);
    @(posedge clk_sys);
    chk("off levels", 32'({primary_drive, secondary_drive, primary_output, secondary_output}),
        32'h3);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_ENABLE, 8'h0f);
    repeat (16) @(posedge clk_sys);
    meas(80);
    chk("indep primary", 32'(pc), 32'd40);
    chk("indep secondary", 32'(sc), 32'd10);
    wr(ADDR_ENABLE, 8'h0b);
    @(posedge clk_sys);
    chk("drive pri", 32'({primary_drive, secondary_drive}), 32'h2);
    wr(ADDR_ENABLE, 8'h0d);
    @(posedge clk_sys);
    chk("drive sec", 32'({primary_drive, secondary_drive}), 32'h1);
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    repeat (3) @(posedge clk_sys);
    chk("irq idle", 32'(overflow_irq_request), 32'h0);
    wr(ADDR_ENABLE, 8'h01);
    repeat (20) @(posedge clk_sys);
    chk("irq timer", 32'(overflow_irq_request), 32'h1);
    rd(ADDR_CONTROL, 8'hc0, 8'hc0, RESP_OKAY, "flag");
    for (int l = 0; l < 4; l++) begin
      wr(ADDR_ENABLE, 8'h00);
      trip_high <= l[0];
      wr(ADDR_CONTROL, {3'h0, l[0], 4'h0});
      wr(ADDR_ENABLE, {1'b0, l[1:0], 5'h17});
      trip <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("fault levels", 32'({primary_output, secondary_output}), 32'(l[1:0]));
      rd(ADDR_CONTROL, 8'h20, 8'h20, RESP_OKAY, "fault set");
      trip <= 1'b0;
      repeat (10) @(posedge clk_sys);
      wr(ADDR_CONTROL, {3'h0, l[0], 4'h0});
      rd(ADDR_CONTROL, 8'h20, 8'h00, RESP_OKAY, "fault clear");
    end
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
endmodule : complementary_pwm_group_12bit_tb_top
